// *** rtl/port_framing_line_mode_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "port_mode_consts.svh"
module port_framing_line_mode_decoder
  import port_mode_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          resetn_i,
  input  wire logic [5:0]    framing_mode_sel_i,
  input  wire logic [2:0]    line_mode_sel_i,
  input  wire logic          cell_align_sel_i,
  input  wire logic          m23_cbit_payload_i,
  input  wire logic          hdlc_mode_i,
  input  wire logic          tx_zero_supp_disable_i,
  input  wire logic          rx_zero_supp_disable_i,
  input  wire logic          payload_loopback_req_i,
  input  wire logic          analog_loopback_req_i,
  input  wire logic          tx_line_clk_i,
  input  wire logic          tx_pos_rail_i,
  input  wire logic          tx_neg_rail_i,
  input  wire logic          rx_line_clk_i,
  input  wire logic          rx_pos_rail_i,
  input  wire logic          rx_neg_lcv_mask_pin_i,
  input  wire logic          tx_ovh_mask_in_i,
  output logic               framer_en_o,
  output logic               all_ones_o,
  output logic               clear_channel_o,
  output logic [1:0]         family_o,
  output logic [2:0]         sub_mode_o,
  output logic               overhead_mask_mode_o,
  output logic               octet_aligned_o,
  output logic               plcp_en_o,
  output logic               frac_en_o,
  output logic               bert_avail_o,
  output logic               payload_loopback_o,
  output align_type          cell_align_o,
  output align_type          hdlc_align_o,
  output logic               hec_byte_hunt_o,
  output logic               hdlc_octet_stuff_o,
  output logic               plcp_bit_search_o,
  output logic               hdlc_blocked_o,
  output logic               g751_fill_en_o,
  output logic [3:0]         g751_fill_o,
  output line_code_type      tx_code_o,
  output line_code_type      rx_code_o,
  output logic               tx_ami_select_o,
  output logic               rx_ami_select_o,
  output logic               liu_en_o,
  output ja_place_type       ja_o,
  output logic               bpv_count_en_o,
  output logic               bpv_pulse_o,
  output logic               tx_ovh_mask_out_o,
  output logic               rx_ovh_mask_o,
  output logic               rx_line_clk_o,
  output logic               rx_pos_rail_o,
  output logic               rx_neg_rail_o,
  output logic               restart_search_o
);
  //////////////////////////////////////////////////////////////////////////
  // mode field decode
  // reserved: framed sub 111, g.832 plcp, clear channel 1xx
  function automatic logic fm_is_reserved(input logic [5:0] fm);
    if (!fm[`FM_CLEAR_BIT])
      fm_is_reserved = (fm[2:0] == 3'h7) ||
                       (fm[4:3] == `FAM_E3_G832 &&
                        (fm[2:0] == `SUB_PLCP ||
                         fm[2:0] == `SUB_PLCP_OHM));
    else
      // clear channel 0x0 plain, 001 mask, 011 octet mask
      fm_is_reserved = fm[2];
  endfunction

  function automatic logic fm_is_ohm(input logic [5:0] fm);
    if (!fm[`FM_CLEAR_BIT])
      fm_is_ohm = (fm[2:0] == `SUB_OHM) || (fm[2:0] == `SUB_PLCP_OHM);
    else
      fm_is_ohm = fm[0];
  endfunction

  logic [5:0]     fm_q;
  logic [2:0]     lm_q;
  port_state_type state;
  port_state_type next_state;
  logic [1:0]     restart_cnt;
  logic           fm_changed;
  logic           illegal;
  logic           clr;
  logic [1:0]     fam;
  logic [2:0]     sub;
  logic           overhead_mask_mode;
  logic           e3;
  logic           is_plcp;
  line_code_type  tx_code;
  line_code_type  rx_code;
  logic           liu_en;
  ja_place_type   ja;
  logic           bpv_en;
  line_code_type  rx_code_unused;
  align_type      next_cell_align;

  assign fm_changed = (framing_mode_sel_i != fm_q) ||
                      (line_mode_sel_i != lm_q);
  assign illegal    = fm_is_reserved(framing_mode_sel_i);
  assign clr        = framing_mode_sel_i[`FM_CLEAR_BIT];
  assign fam        = framing_mode_sel_i[`FM_FAM_HI:`FM_FAM_LO];
  assign sub        = clr ? `SUB_DIRECT : framing_mode_sel_i[2:0];
  // reserved codes are no mask mode: keeps bpv and mask outputs in step
  assign overhead_mask_mode        = fm_is_ohm(framing_mode_sel_i) &&
                      !illegal;
  assign e3         = fam[1];
  assign is_plcp    = !clr && (sub == `SUB_PLCP || sub == `SUB_PLCP_OHM);

  //////////////////////////////////////////////////////////////////////////
  // line mode per direction
  line_mode_decode u_tx_line (
    .line_mode_sel_i     (line_mode_sel_i),
    .zero_supp_disable_i (tx_zero_supp_disable_i),
    .e3_family_i         (e3),
    .ohm_mode_i          (overhead_mask_mode),
    .code_o              (tx_code),
    .liu_en_o            (liu_en),
    .ja_o                (ja),
    .bpv_count_en_o      ()
  );

  line_mode_decode u_rx_line (
    .line_mode_sel_i     (line_mode_sel_i),
    .zero_supp_disable_i (rx_zero_supp_disable_i),
    .e3_family_i         (e3),
    .ohm_mode_i          (overhead_mask_mode),
    .code_o              (rx_code),
    .liu_en_o            (),
    .ja_o                (),
    .bpv_count_en_o      (bpv_en)
  );
  assign rx_code_unused = rx_code;

  //////////////////////////////////////////////////////////////////////////
  // port state
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN:
        if (illegal)
          next_state = ST_ILLEGAL;
        else if (fm_changed)
          next_state = ST_RESTART;
      // go to run only once the count runs out with no further change
      ST_RESTART:
        if (illegal)
          next_state = ST_ILLEGAL;
        else if (restart_cnt == 2'h0 && !fm_changed)
          next_state = ST_RUN;
      ST_ILLEGAL:
        if (!illegal)
          next_state = ST_RESTART;
      default: next_state = ST_ILLEGAL;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_RESTART;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fm_q        <= `FM_RESET;
      lm_q        <= `LM_RESET;
      restart_cnt <= `RESTART_CYCLES;
    end else begin
      fm_q <= framing_mode_sel_i;
      lm_q <= line_mode_sel_i;
      if (fm_changed || illegal)
        restart_cnt <= `RESTART_CYCLES;
      else if (restart_cnt != 2'h0)
        restart_cnt <= restart_cnt - 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // alignment
  // m23 with payload c-bits keeps no nibble grid, so cells go bitwise
  always_comb begin
    next_cell_align = AL_BIT;
    if (clr)
      next_cell_align = (overhead_mask_mode && framing_mode_sel_i[1]) ? AL_BYTE : AL_BIT;
    else if (is_plcp)
      next_cell_align = e3 ? AL_BYTE : AL_NIBBLE;
    else if (sub == `SUB_DIRECT)
      case (fam)
        `FAM_DS3_CBIT, `FAM_DS3_M23:
          next_cell_align = (cell_align_sel_i || (fam == `FAM_DS3_M23 &&
                             m23_cbit_payload_i)) ? AL_BIT
                                                  : AL_NIBBLE;
        `FAM_E3_G751: next_cell_align = AL_BIT;
        `FAM_E3_G832:
          next_cell_align = cell_align_sel_i ? AL_BIT : AL_BYTE;
        default: next_cell_align = AL_BIT;
      endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // registered decode outputs
  // all-ones and idle framer while the code is reserved
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      framer_en_o          <= 1'b0;
      all_ones_o           <= 1'b1;
      clear_channel_o      <= 1'b0;
      family_o             <= 2'h0;
      sub_mode_o           <= 3'h0;
      overhead_mask_mode_o <= 1'b0;
      octet_aligned_o      <= 1'b0;
      plcp_en_o            <= 1'b0;
      frac_en_o            <= 1'b0;
      bert_avail_o         <= 1'b0;
      payload_loopback_o   <= 1'b0;
      cell_align_o         <= AL_BIT;
      hdlc_align_o         <= AL_BIT;
      hec_byte_hunt_o      <= 1'b0;
      hdlc_octet_stuff_o   <= 1'b0;
      plcp_bit_search_o    <= 1'b0;
      hdlc_blocked_o       <= 1'b0;
      g751_fill_en_o       <= 1'b0;
      g751_fill_o          <= 4'h0;
      restart_search_o     <= 1'b1;
    end else begin
      framer_en_o      <= (next_state == ST_RUN);
      all_ones_o       <= (next_state == ST_ILLEGAL);
      restart_search_o <= (next_state != ST_RUN);
      clear_channel_o  <= clr;
      family_o         <= fam;
      sub_mode_o       <= sub;
      overhead_mask_mode_o <= overhead_mask_mode && !illegal;
      octet_aligned_o  <= clr && overhead_mask_mode && framing_mode_sel_i[1];
      plcp_en_o        <= is_plcp && !illegal &&
                          !(fam == `FAM_DS3_M23 && m23_cbit_payload_i);
      frac_en_o        <= !clr && (sub == `SUB_IFRAC || sub == `SUB_XFRAC ||
                          sub == `SUB_FFRAC);
      bert_avail_o     <= 1'b1;
      payload_loopback_o <= payload_loopback_req_i && !overhead_mask_mode && !illegal;
      cell_align_o     <= next_cell_align;
      hdlc_align_o     <= (clr && overhead_mask_mode && framing_mode_sel_i[1]) ? AL_BYTE
                                                                : AL_BIT;
      hec_byte_hunt_o  <= clr && overhead_mask_mode && framing_mode_sel_i[1];
      hdlc_octet_stuff_o <= clr && overhead_mask_mode && framing_mode_sel_i[1];
      plcp_bit_search_o <= is_plcp;
      hdlc_blocked_o   <= is_plcp && hdlc_mode_i;
      g751_fill_en_o   <= is_plcp && fam == `FAM_E3_G751;
      g751_fill_o      <= (is_plcp && fam == `FAM_E3_G751) ?
                          `G751_PLCP_FILL : 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // line side
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_code_o         <= LC_UNI;
      rx_code_o         <= LC_UNI;
      tx_ami_select_o   <= 1'b0;
      rx_ami_select_o   <= 1'b0;
      liu_en_o          <= 1'b0;
      ja_o              <= JA_OFF;
      bpv_count_en_o    <= 1'b0;
      bpv_pulse_o       <= 1'b0;
      tx_ovh_mask_out_o <= 1'b0;
      rx_ovh_mask_o     <= 1'b0;
      rx_line_clk_o     <= 1'b0;
      rx_pos_rail_o     <= 1'b0;
      rx_neg_rail_o     <= 1'b0;
    end else begin
      tx_code_o       <= tx_code;
      rx_code_o       <= rx_code_unused;
      tx_ami_select_o <= tx_code == LC_AMI;
      rx_ami_select_o <= rx_code_unused == LC_AMI;
      liu_en_o        <= liu_en;
      ja_o            <= ja;
      bpv_count_en_o  <= bpv_en;
      bpv_pulse_o     <= bpv_en && rx_neg_lcv_mask_pin_i;
      tx_ovh_mask_out_o <= overhead_mask_mode && tx_ovh_mask_in_i;
      rx_ovh_mask_o   <= overhead_mask_mode && rx_neg_lcv_mask_pin_i;
      // digital loopback only with the line interface unit off
      if (analog_loopback_req_i && !liu_en) begin
        rx_line_clk_o <= tx_line_clk_i;
        rx_pos_rail_o <= tx_pos_rail_i;
        rx_neg_rail_o <= tx_neg_rail_i;
      end else begin
        rx_line_clk_o <= rx_line_clk_i;
        rx_pos_rail_o <= rx_pos_rail_i;
        // in mask modes this pin carries the mask, not a rail
        rx_neg_rail_o <= overhead_mask_mode ? 1'b0 : rx_neg_lcv_mask_pin_i;
      end
    end
  end
endmodule // port_framing_line_mode_decoder
`default_nettype wire

// *** rtl/port_mode_consts.svh ***
// What this block does
// - framing mode from own six-bit field
// - framed family and sub-mode decode
// - G.832 PLCP codes reserved, E3 PLCP G.751
// - clear-channel mode when top bit set
// - overhead-mask modes use mask pins, unipolar
// - payload loopback off in mask modes
// - octet-aligned mask modes octet stuff
// - HEC hunt bitwise, bytewise in octet mask
// - PLCP searched bitwise, cells only
// - DS3 direct cells nibble/bit, HDLC bit
// - DS3 PLCP nibble aligned, ignore align bit
// - DS3 PLCP only with generated C-bits
// - G.751 PLCP forces bits 13-16 to 1100
// - G.751 direct bit-aligns cells and packets
// - G.832 cells byte/bit, HDLC bit aligned
// - line mode selects LINE_INTERFACE_UNIT and attenuator
// - bipolar code B3ZS/HDB3 or AMI
// - unipolar: no coding, counter still counts
// - no violation counting in mask modes
// - analog loopback analog or digital path
`ifndef PORT_MODE_CONSTS_SVH
`define PORT_MODE_CONSTS_SVH
`define FAM_DS3_CBIT     2'h0
`define FAM_DS3_M23      2'h1
`define FAM_E3_G751      2'h2
`define FAM_E3_G832      2'h3
`define SUB_DIRECT       3'h0
`define SUB_OHM          3'h1
`define SUB_IFRAC        3'h2
`define SUB_XFRAC        3'h3
`define SUB_PLCP         3'h4
`define SUB_PLCP_OHM     3'h5
`define SUB_FFRAC        3'h6
`define FM_CLEAR_BIT     5
`define FM_FAM_HI        4
`define FM_FAM_LO        3
`define G751_PLCP_FILL   4'hC
`define FM_RESET         6'h00
`define LM_RESET         3'h0
`define RESTART_CYCLES   2'h2
`endif

// *** rtl/port_mode_pkg.sv ***
package port_mode_pkg;
  typedef enum logic [1:0] {
    LC_UNI  = 2'h0,
    LC_B3ZS = 2'h1,
    LC_HDB3 = 2'h2,
    LC_AMI  = 2'h3
  } line_code_type;
  typedef enum logic [1:0] {
    JA_OFF = 2'h0,
    JA_TX  = 2'h1,
    JA_RX  = 2'h2
  } ja_place_type;
  typedef enum logic [1:0] {
    AL_BIT    = 2'h0,
    AL_NIBBLE = 2'h1,
    AL_BYTE   = 2'h2
  } align_type;
  typedef enum logic [1:0] {
    ST_RUN     = 2'h0,
    ST_RESTART = 2'h1,
    ST_ILLEGAL = 2'h3
  } port_state_type;
endpackage

// *** rtl/line_mode_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_mode_decode
  import port_mode_pkg::*;
(
  input  wire logic [2:0]    line_mode_sel_i,
  input  wire logic          zero_supp_disable_i,
  input  wire logic          e3_family_i,
  input  wire logic          ohm_mode_i,
  output line_code_type      code_o,
  output logic               liu_en_o,
  output ja_place_type       ja_o,
  output logic               bpv_count_en_o
);
  always_comb begin
    liu_en_o = 1'b0;
    ja_o     = JA_OFF;
    code_o   = LC_UNI;
    if (!line_mode_sel_i[2]) begin
      liu_en_o = (line_mode_sel_i != 3'h0);
      case (line_mode_sel_i[1:0])
        2'h2:    ja_o = JA_TX;
        2'h3:    ja_o = JA_RX;
        default: ja_o = JA_OFF;
      endcase
      if (zero_supp_disable_i)
        code_o = LC_AMI;
      else
        code_o = e3_family_i ? LC_HDB3 : LC_B3ZS;
    end
    if (ohm_mode_i)
      code_o = LC_UNI;
    // unipolar still counts external pulses, mask modes do not
    bpv_count_en_o = !ohm_mode_i;
  end
endmodule // line_mode_decode
`default_nettype wire

// *** tb/mode_checker_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module mode_checker (
  input wire logic       core_clk_i,
  input wire logic       resetn_i,
  input wire logic [5:0] framing_mode_sel_i,
  input wire logic [2:0] line_mode_sel_i,
  input wire logic       framer_en_o,
  input wire logic       all_ones_o,
  input wire logic       clear_channel_o,
  input wire logic [1:0] family_o,
  input wire logic       overhead_mask_mode_o,
  input wire logic       payload_loopback_o,
  input wire logic       bert_avail_o,
  input wire logic       plcp_en_o,
  input wire logic       g751_fill_en_o,
  input wire logic [3:0] g751_fill_o,
  input wire logic       restart_search_o,
  input wire logic       bpv_count_en_o,
  input wire logic       liu_en_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////
  a_bert_every_mode: assert property (
    $past(resetn_i) |-> bert_avail_o) else $error("bert not available");
  a_family_follows: assert property (
    $past(resetn_i) && !all_ones_o |->
    family_o == $past(framing_mode_sel_i[4:3])) else $error("family wrong");
  a_clear_select: assert property (
    $past(resetn_i) && !all_ones_o |->
    clear_channel_o == $past(framing_mode_sel_i[5])) else $error("clear wrong");
  a_reserved_idle: assert property (
    $past(resetn_i) && $past(framing_mode_sel_i[5:1]) == 5'h0E |->
    all_ones_o && !framer_en_o) else $error("reserved code accepted");
  a_plb_mask_off: assert property (
    overhead_mask_mode_o |-> !payload_loopback_o) else $error("loopback on");
  a_g751_fill: assert property (
    plcp_en_o && family_o == 2'h2 && !clear_channel_o |->
    g751_fill_en_o && g751_fill_o == 4'hC) else $error("fill wrong");
  a_bpv_mask_off: assert property (
    $past(resetn_i) |-> bpv_count_en_o != overhead_mask_mode_o)
    else $error("bpv enable wrong");
  a_change_restart: assert property (
    $changed(framing_mode_sel_i) || $changed(line_mode_sel_i) |=>
    restart_search_o && !framer_en_o) else $error("no restart");
  a_restart_bound: assert property (
    ($stable(framing_mode_sel_i) && $stable(line_mode_sel_i) && !all_ones_o)[*5]
    |-> framer_en_o && !restart_search_o) else $error("restart too long");
  a_liu_line: assert property (
    $past(resetn_i) |->
    liu_en_o == ($past(line_mode_sel_i) inside {3'h1, 3'h2, 3'h3}))
    else $error("liu enable wrong");
  c_mask_mode: cover property (overhead_mask_mode_o && !all_ones_o);
  c_g751_plcp: cover property (g751_fill_en_o);
  c_reserved: cover property ($past(resetn_i) && all_ones_o);
endmodule // mode_checker
bind port_framing_line_mode_decoder mode_checker mode_checker_i (.*);
`default_nettype wire

// *** tb/line_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_side_model (
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic ohm_i,
  input  wire logic freeze_i,
  output logic      tx_line_clk_o,
  output logic      tx_pos_rail_o,
  output logic      tx_neg_rail_o,
  output logic      rx_line_clk_o,
  output logic      rx_pos_rail_o,
  output logic      rx_neg_pin_o,
  output logic      tx_ovh_mask_o
);
  logic [3:0] pat;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pat <= 4'h0;
    end else if (!freeze_i) begin
      pat <= pat + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // rx side inverse of tx so a wrong path shows
  assign tx_line_clk_o = pat[0];
  assign tx_pos_rail_o = pat[1];
  assign tx_neg_rail_o = !pat[1];
  assign rx_line_clk_o = !pat[0];
  assign rx_pos_rail_o = !pat[1];
  assign rx_neg_pin_o  = ohm_i ? pat[2] : pat[1];
  assign tx_ovh_mask_o = ohm_i & pat[2];
endmodule // line_side_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import port_mode_pkg::*;
  logic core_clk_i = 0, resetn_i = 0, freeze = 0;
  logic [5:0] framing_mode_sel_i = 6'h00;
  logic [2:0] line_mode_sel_i = 3'h0;
  logic cell_align_sel_i = 0, m23_cbit_payload_i = 0, hdlc_mode_i = 0;
  logic tx_zero_supp_disable_i = 0, rx_zero_supp_disable_i = 0;
  logic payload_loopback_req_i = 0, analog_loopback_req_i = 0;
  wire logic tx_line_clk_i, tx_pos_rail_i, tx_neg_rail_i, rx_line_clk_i;
  wire logic rx_pos_rail_i, rx_neg_lcv_mask_pin_i, tx_ovh_mask_in_i;
  logic framer_en_o, all_ones_o, clear_channel_o, overhead_mask_mode_o;
  logic octet_aligned_o, plcp_en_o, frac_en_o, bert_avail_o, liu_en_o;
  logic payload_loopback_o, hec_byte_hunt_o, hdlc_octet_stuff_o;
  logic plcp_bit_search_o, hdlc_blocked_o, g751_fill_en_o, bpv_pulse_o;
  logic tx_ami_select_o, rx_ami_select_o, bpv_count_en_o, rx_line_clk_o;
  logic tx_ovh_mask_out_o, rx_ovh_mask_o, rx_pos_rail_o, rx_neg_rail_o;
  logic restart_search_o;
  logic [1:0] family_o;
  logic [2:0] sub_mode_o;
  logic [3:0] g751_fill_o;
  align_type cell_align_o, hdlc_align_o;
  line_code_type tx_code_o, rx_code_o;
  ja_place_type ja_o;
  int failures = 0, comparisons = 0;
  port_framing_line_mode_decoder port_framing_line_mode_decoder_i (.*);
  line_side_model line_side_model_i (.core_clk_i, .resetn_i,
    .ohm_i(overhead_mask_mode_o), .freeze_i(freeze),
    .tx_line_clk_o(tx_line_clk_i), .tx_pos_rail_o(tx_pos_rail_i),
    .tx_neg_rail_o(tx_neg_rail_i), .rx_line_clk_o(rx_line_clk_i),
    .rx_pos_rail_o(rx_pos_rail_i), .rx_neg_pin_o(rx_neg_lcv_mask_pin_i),
    .tx_ovh_mask_o(tx_ovh_mask_in_i));
  initial begin
    forever #2.5 core_clk_i = !core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [3:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic setm(input logic [5:0] fm, input logic [2:0] lm);
    @(negedge core_clk_i);
    framing_mode_sel_i = fm;
    line_mode_sel_i = lm;
    repeat (7) @(negedge core_clk_i);
  endtask
  function automatic line_code_type lcode(input logic e3, lu, z);
    return lu ? LC_UNI : z ? LC_AMI : e3 ? LC_HDB3 : LC_B3ZS;
  endfunction
  task automatic t_framed;
    logic [2:0] s;
    logic lg, overhead_mask_mode;
    payload_loopback_req_i = 1;
    for (int f = 0; f < 4; f++) begin
      for (int i = 0; i < 8; i++) begin
        s = 3'(i);
        lg = !(f == 3 && s[2:1] == 2'h2) && s != 3'h7;
        overhead_mask_mode = s == 3'h1 || s == 3'h5;
        setm({1'b0, 2'(f), s}, 3'h4);
        chk("all_ones", 4'(all_ones_o), 4'(!lg));
        chk("framer_en", 4'(framer_en_o), 4'(lg));
        chk("bert", 4'(bert_avail_o), 4'h1);
        if (lg) begin
          chk("family", 4'(family_o), 4'(f));
          chk("sub_mode", 4'(sub_mode_o), 4'(s));
          chk("frac", 4'(frac_en_o), 4'(s inside {2, 3, 6}));
          chk("ohm", 4'(overhead_mask_mode_o), 4'(overhead_mask_mode));
          chk("plcp", 4'(plcp_en_o), 4'(s[2:1] == 2'h2));
          chk("plb", 4'(payload_loopback_o), 4'(!overhead_mask_mode));
        end
      end
    end
  endtask
  task automatic t_clear;
    logic [2:0] s;
    hdlc_mode_i = 1;
    for (int f = 0; f < 4; f++) begin
      for (int i = 0; i < 5; i++) begin
        s = 3'(i);
        setm({1'b1, 2'(f), s}, 3'h4);
        chk("all_ones", 4'(all_ones_o), 4'(s == 3'h4));
        if (s != 3'h4) begin
          chk("clear", 4'(clear_channel_o), 4'h1);
          chk("ohm", 4'(overhead_mask_mode_o), 4'(s[0]));
          chk("octet", 4'(octet_aligned_o), 4'(s == 3'h3));
          chk("stuff", 4'(hdlc_octet_stuff_o), 4'(s == 3'h3));
          chk("hec_byte", 4'(hec_byte_hunt_o), 4'(s == 3'h3));
        end
      end
    end
    hdlc_mode_i = 0;
  endtask
  task automatic t_line;
    logic [5:0] fms [4] = '{6'h00, 6'h10, 6'h28, 6'h30};
    foreach (fms[k]) for (int m = 0; m < 16; m++) begin
      tx_zero_supp_disable_i = m[3];
      rx_zero_supp_disable_i = !m[3];
      setm(fms[k], 3'(m));
      chk("tx_code", 4'(tx_code_o), 4'(lcode(fms[k][4], m[2], m[3])));
      chk("rx_code", 4'(rx_code_o), 4'(lcode(fms[k][4], m[2], !m[3])));
      chk("tx_ami", 4'(tx_ami_select_o), 4'(!m[2] && m[3]));
      chk("rx_ami", 4'(rx_ami_select_o), 4'(!m[2] && !m[3]));
      chk("liu", 4'(liu_en_o), 4'(m[2:0] inside {1, 2, 3}));
      chk("ja", 4'(ja_o), m[2:0] == 2 ? 4'h1 : m[2:0] == 3 ? 4'h2 : 4'h0);
      chk("bpv_en", 4'(bpv_count_en_o), 4'h1);
    end
  endtask
  task automatic al(input logic [5:0] fm, input logic [2:0] ctl,
                    input align_type ec, eh);
    {cell_align_sel_i, hdlc_mode_i, m23_cbit_payload_i} = ctl;
    setm(fm, 3'h1);
    chk("cell_align", 4'(cell_align_o), 4'(ec));
    chk("hdlc_align", 4'(hdlc_align_o), 4'(eh));
  endtask
  task automatic t_align;
    al(6'h00, 3'b000, AL_NIBBLE, AL_BIT);
    al(6'h00, 3'b110, AL_BIT, AL_BIT);
    al(6'h08, 3'b101, AL_BIT, AL_BIT);
    al(6'h10, 3'b010, AL_BIT, AL_BIT);
    al(6'h18, 3'b000, AL_BYTE, AL_BIT);
    al(6'h18, 3'b110, AL_BIT, AL_BIT);
    al(6'h04, 3'b100, AL_NIBBLE, AL_BIT);
    al(6'h14, 3'b100, AL_BYTE, AL_BIT);
    chk("fill", g751_fill_o, 4'hC);
    al(6'h04, 3'b010, AL_NIBBLE, AL_BIT);
    chk("blocked", 4'(hdlc_blocked_o), 4'h1);
    chk("plcp_search", 4'(plcp_bit_search_o), 4'h1);
    al(6'h0C, 3'b101, AL_NIBBLE, AL_BIT);
    chk("plcp", 4'(plcp_en_o), 4'h0);
    al(6'h12, 3'b100, AL_BIT, AL_BIT);
    chk("frac", 4'(frac_en_o), 4'h1);
    chk("fill_en", 4'(g751_fill_en_o), 4'h0);
  endtask
  task automatic t_loop;
    analog_loopback_req_i = 1;
    setm(6'h00, 3'h0);
    freeze = 1;
    repeat (4) @(negedge core_clk_i);
    chk("lb_clk", 4'(rx_line_clk_o), 4'(tx_line_clk_i));
    chk("lb_pos", 4'(rx_pos_rail_o), 4'(tx_pos_rail_i));
    chk("lb_neg", 4'(rx_neg_rail_o), 4'(tx_neg_rail_i));
    setm(6'h00, 3'h1);
    chk("rx_clk", 4'(rx_line_clk_o), 4'(rx_line_clk_i));
    chk("rx_pos", 4'(rx_pos_rail_o), 4'(rx_pos_rail_i));
    chk("rx_neg", 4'(rx_neg_rail_o), 4'(rx_neg_lcv_mask_pin_i));
    freeze = 0;
    analog_loopback_req_i = 0;
  endtask
  task automatic t_bpv_restart;
    int n, nt, nr;
    for (int o = 0; o < 2; o++) begin
      n = 0;
      nt = 0;
      nr = 0;
      setm(o ? 6'h01 : 6'h00, 3'h4);
      repeat (8) begin
        @(negedge core_clk_i);
        n += int'(bpv_pulse_o === 1'b1);
        nt += int'(tx_ovh_mask_out_o === 1'b1);
        nr += int'(rx_ovh_mask_o === 1'b1);
      end
      chk("bpv_seen", 4'(n > 0), 4'(o == 0));
      chk("tx_mask_seen", 4'(nt > 0), 4'(o == 1));
      chk("rx_mask_seen", 4'(nr > 0), 4'(o == 1));
    end
    framing_mode_sel_i = 6'h08;
    repeat (2) @(negedge core_clk_i);
    chk("restart", 4'(restart_search_o), 4'h1);
    chk("framer_en", 4'(framer_en_o), 4'h0);
    repeat (4) @(negedge core_clk_i);
    chk("framer_en", 4'(framer_en_o), 4'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk_i);
    resetn_i = 1;
    t_framed;
    t_clear;
    t_line;
    t_align;
    t_loop;
    t_bpv_restart;
    results;
  end
  initial begin
    #50000;
    failures++;
    results;
  end
endmodule // testbench
`default_nettype wire
